// ===== dv/tss_host_model.sv
// Purpose: Bus master model driving the two-wire clock and data lines
// Assumes: sda is the resolved wire, pulled up while nobody pulls it low
// Notes: A quarter bit is five system clocks, giving a 160 ns bus clock
`timescale 1ns/1ns
module tss_host_model (
   input wire logic clock,
   input wire logic sda,
   output logic scl,
   output logic sda_oe
);
   // Bus clock idles high and stands still between frames
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   // Wait a quarter bit, stepping just after the edge
   task q();
      repeat (5) @(posedge clock);
      #1;
   endtask : q
   // One bus clock: data set while low, sampled while high
   task clk_bit(input logic d, output logic s);
      sda_oe = ~d;
      q();
      scl = 1'b1;
      q();
      s = sda;
      q();
      scl = 1'b0;
      q();
   endtask : clk_bit
   // Start or repeated start: data falls while clock high
   task start();
      sda_oe = 1'b0;
      q();
      scl = 1'b1;
      q();
      sda_oe = 1'b1;
      q();
      scl = 1'b0;
      q();
   endtask : start
   // Stop: data rises while clock high
   task stop();
      sda_oe = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_oe = 1'b0;
      q();
   endtask : stop
   // Byte with high bit first, then the ninth clock
   task xfer(input logic [7:0] o, input logic l9, output logic [7:0] i, output logic s9);
      for (int k = 7; k >= 0; k--) begin
         clk_bit(o[k], i[k]);
      end
      clk_bit(l9, s9);
   endtask : xfer
endmodule : tss_host_model

// ===== dv/tss_slave_tb.sv
// Purpose: Self-checking bench for the sensor slave through its serial bus
// Assumes: Host model in tss_host_model.sv, shortened long intervals
// Notes: Address pins held at 101
`timescale 1ns/1ns
module tss_slave_tb;
   localparam int unsigned TOUT = 2000; // Shortened link timeout
   localparam int unsigned CONV = 500; // Shortened conversion period
   localparam logic [15:0] MAKER = 16'h00C3; // Arbitrary value
   localparam logic [15:0] REV = 16'h003C; // Arbitrary value
   localparam logic [6:0] DEV = 7'h1D; // Preamble 0011, pins 101
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [12:0] code = 13'h0000; // Converter result
   logic [2:0] pins = 3'b101;
   logic scl, m_oe, s_oe, s_out, ev_oe, ev_out;
   int failures = 0;
   int samples_checked = 0;
   logic [15:0] v;
   logic [7:0] b;
   logic a;
   logic ok; // All acknowledges seen in one transfer
   wire sda = ~(m_oe | s_oe); // Pull-up wire
   always #4 clock = ~clock;
   tss_host_model host (.clock(clock), .sda(sda), .scl(scl), .sda_oe(m_oe));
   tss_slave #(.TIMEOUT_CYCLES(TOUT), .CONV_CYCLES(CONV), .MAKER_CODE(MAKER),
      .REVISION_CODE(REV)) uut (.clock(clock), .reset(reset), .scl_in(scl),
      .sda_in(sda), .sda_out(s_out), .sda_oe(s_oe), .address_select_bit0(pins[0]),
      .address_select_bit1(pins[1]), .address_select_bit2(pins[2]),
      .sensor_code(code), .event_out(ev_out), .event_oe(ev_oe));
   // Compare and count
   task check(input string n, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   // Counts and verdict
   task stop_test();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test
   task done(input string n);
      $display("test %s done", n);
   endtask : done
   task wait_cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : wait_cyc
   // Byte from the master, collecting the slave acknowledge
   task send(input logic [7:0] o);
      host.xfer(o, 1'b1, b, a);
      ok = ok & ~a;
   endtask : send
   // Register write; short form sends only the high byte
   task wr(input logic [2:0] p, input logic [15:0] d, input logic full);
      ok = 1'b1;
      host.start();
      send({DEV, 1'b0});
      send({5'h00, p});
      send(d[15:8]);
      if (full) begin
         send(d[7:0]);
      end
      host.stop();
      check("write ack", ok, 16'h0001);
   endtask : wr
   // Selective read, or immediate read when sel is low
   task rd(input logic [2:0] p, input logic sel, output logic [15:0] d);
      ok = 1'b1;
      host.start();
      if (sel) begin
         send({DEV, 1'b0});
         send({5'h00, p});
         host.start();
      end
      send({DEV, 1'b1});
      host.xfer(8'hFF, 1'b0, d[15:8], a);
      host.xfer(8'hFF, 1'b1, d[7:0], a);
      host.stop();
      check("read ack", ok, 16'h0001);
   endtask : rd
   // Main sequence
   initial begin
      wait_cyc(5);
      reset = 1'b0;
      wait_cyc(3);
      check("event idle", ev_oe, 16'h0000);
      check("sda idle", s_oe, 16'h0000);
      host.start();
      host.xfer({DEV, 1'b1}, 1'b1, b, a);
      check("addr ack", a, 16'h0000);
      check("first bit", s_oe, 16'h0001);
      wait_cyc(TOUT + 100);
      check("timeout", s_oe, 16'h0000);
      host.stop();
      done("timeout");
      rd(3'h0, 1'b0, v);
      check("capability", v, 16'h0077);
      for (int p = 1; p < 5; p++) begin
         rd(p[2:0], 1'b1, v);
         check("reset value", v, 16'h0000);
      end
      rd(3'h6, 1'b1, v);
      check("maker", v, MAKER);
      rd(3'h7, 1'b1, v);
      check("revision", v, REV);
      done("reset");
      code = 13'h1FF0;
      wait_cyc(CONV + 100);
      rd(3'h5, 1'b1, v);
      check("negative", v, 16'h3FF0);
      code = 13'h0190;
      wait_cyc(CONV + 100);
      rd(3'h5, 1'b1, v);
      check("over", v, 16'hC190);
      wr(3'h2, 16'h0640, 1'b1);
      wr(3'h4, 16'h0640, 1'b1);
      rd(3'h5, 1'b1, v);
      check("new limits", v, 16'h0190);
      wr(3'h3, 16'h0200, 1'b1);
      rd(3'h5, 1'b1, v);
      check("under", v, 16'h2190);
      done("compare");
      rd(3'h2, 1'b1, v);
      check("upper", v, 16'h0640);
      rd(3'h0, 1'b0, v);
      check("pointer", v, 16'h0640);
      wr(3'h0, 16'h1234, 1'b1);
      rd(3'h0, 1'b1, v);
      check("read only", v, 16'h0077);
      wr(3'h3, 16'h00AA, 1'b0);
      rd(3'h3, 1'b1, v);
      check("short write", v, 16'h0200);
      host.start();
      host.xfer({7'h1A, 1'b0}, 1'b1, b, a);
      host.stop();
      check("foreign addr", a, 16'h0001);
      done("access");
      wr(3'h1, 16'h0008, 1'b1);
      check("event on", ev_oe, 16'h0001);
      wr(3'h1, 16'h0000, 1'b1);
      check("event off", ev_oe, 16'h0000);
      wr(3'h1, 16'h0100, 1'b1);
      rd(3'h1, 1'b1, v);
      check("config", v, 16'h0100);
      code = 13'h0050;
      wait_cyc(CONV + 100);
      rd(3'h5, 1'b1, v);
      check("frozen", v, 16'h2190);
      wr(3'h1, 16'h0000, 1'b1);
      wait_cyc(CONV + 100);
      rd(3'h5, 1'b1, v);
      check("resumed", v, 16'h2050);
      done("shutdown");
      // Interrupt mode keeps the recorded event until a clear
      wr(3'h1, 16'h0009, 1'b1);
      wait_cyc(2);
      check("latched", ev_oe, 16'h0001);
      wr(3'h1, 16'h0029, 1'b1);
      wait_cyc(2);
      check("cleared", ev_oe, 16'h0000);
      wr(3'h3, 16'h0000, 1'b1);
      wr(3'h3, 16'h0200, 1'b1);
      wait_cyc(2);
      check("limit event", ev_oe, 16'h0001);
      // Active-high polarity releases the pin while the event shows
      wr(3'h1, 16'h000A, 1'b1);
      wait_cyc(2);
      check("polarity", ev_oe, 16'h0000);
      rd(3'h1, 1'b1, v);
      check("status copy", v, 16'h001A);
      check("sda value", s_out, 16'h0000);
      check("event value", ev_out, 16'h0000);
      done("event");
      stop_test();
   end
   // Watchdog against a hung bus
   initial begin
      repeat (60000) @(posedge clock);
      failures++;
      $display("Error watchdog expected finish seen hang");
      stop_test();
   end
endmodule : tss_slave_tb

// ===== rtl/tss_defines.svh
// Purpose: Offsets, field positions, reset values and timing figures of the sensor slave
// Assumes: Included by bare name wherever these constants are needed
// Notes: Definitions only
`ifndef TSS_DEFINES_SVH
`define TSS_DEFINES_SVH
// Register pointer values
`define TSS_PTR_CAPABILITY 3'h0
`define TSS_PTR_CONFIG 3'h1
`define TSS_PTR_UPPER 3'h2
`define TSS_PTR_LOWER 3'h3
`define TSS_PTR_CRITICAL 3'h4
`define TSS_PTR_TEMPERATURE 3'h5
`define TSS_PTR_MAKER 3'h6
`define TSS_PTR_REVISION 3'h7
// Reset values
`define TSS_CAPABILITY_VALUE 16'h0077
`define TSS_REG_RESET 16'h0000
`define TSS_PTR_RESET 3'h0
// Fixed upper four bits of the slave address
`define TSS_ADDR_PREAMBLE 4'h3
// Configuration field positions
`define TSS_CFG_HYST_LSB 9
`define TSS_CFG_SHDN 8
`define TSS_CFG_LOCK_CRIT 7
`define TSS_CFG_LOCK_ALARM 6
`define TSS_CFG_CLEAR 5
`define TSS_CFG_STS 4
`define TSS_CFG_CTRL 3
`define TSS_CFG_CRIT_ONLY 2
`define TSS_CFG_POL 1
`define TSS_CFG_MODE 0
// Timing: clock rate and the two long intervals
`define TSS_CLK_MHZ 125
`define TSS_TIMEOUT_MS 25
`define TSS_CONV_MS 100
`define TSS_TIMEOUT_CYCLES (`TSS_TIMEOUT_MS * 1000 * `TSS_CLK_MHZ)
`define TSS_CONV_CYCLES (`TSS_CONV_MS * 1000 * `TSS_CLK_MHZ)
`endif

// ===== rtl/tss_pkg.sv
// Purpose: Types shared by the sensor slave
// Assumes: Nothing
// Notes: Constants live in tss_defines.svh
package tss_pkg;
   // Serial engine states, one-hot
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_ADDR = 9'h002,
      ST_ACK_ADDR = 9'h004,
      ST_PTR = 9'h008,
      ST_ACK_PTR = 9'h010,
      ST_WR = 9'h020,
      ST_ACK_WR = 9'h040,
      ST_RD = 9'h080,
      ST_ACK_RD = 9'h100
   } tss_state_type;
   // Stored configuration fields
   typedef struct packed {
      logic [1:0] hyst;
      logic shdn;
      logic lock_crit;
      logic lock_alarm;
      logic crit_only;
      logic pol;
      logic ctrl;
      logic mode;
   } tss_cfg_type;
   // Limit comparison results
   typedef struct packed {
      logic over_crit;
      logic over_high;
      logic under_low;
   } tss_trip_type;
endpackage : tss_pkg

// ===== rtl/tss_slave.sv
// Purpose: Two-wire slave and register set of a digital temperature sensor
// Assumes: scl, sda, address pins and sensor code come from outside and are synchronised here
// Notes: sda and the event pin are open drain, driven low only while their enable is high
`timescale 1ns/1ns
`include "tss_defines.svh"
module tss_slave #(
   parameter int unsigned TIMEOUT_CYCLES = `TSS_TIMEOUT_CYCLES,
   parameter int unsigned CONV_CYCLES = `TSS_CONV_CYCLES,
   parameter logic [15:0] MAKER_CODE = 16'h00A5,   // Arbitrary value
   parameter logic [15:0] REVISION_CODE = 16'h005A // Arbitrary value
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic address_select_bit0,
   input wire logic address_select_bit1,
   input wire logic address_select_bit2,
   input wire logic [12:0] sensor_code,
   output logic event_out,
   output logic event_oe
);
   // Refuse counts the counters cannot serve
   if (TIMEOUT_CYCLES < 2 || CONV_CYCLES < 2) begin : g_bad_counts
      $error("Cycle counts must be at least two");
   end

   // Pin synchronisers, third stage for edge detection
   logic scl_s1_q, scl_s2_q, scl_s3_q;
   logic sda_s1_q, sda_s2_q, sda_s3_q;
   logic [2:0] asel_s1_q, asel_s2_q;
   logic [12:0] code_s1_q, code_s2_q;

   // Serial engine state
   tss_pkg::tss_state_type state_q;
   logic [3:0] cnt_q;        // Bits moved in the current byte
   logic [7:0] shift_q;      // Received byte
   logic [7:0] tx_q;         // Byte being sent
   logic rw_q;               // Direction bit of the last address
   logic byte_lo_q;          // Next read byte is the low byte
   logic mack_q;             // Master acknowledged the last read byte
   logic [1:0] wr_cnt_q;     // Data bytes received, saturating at 3
   logic [2:0] ptr_q;        // Register pointer
   logic [15:0] wdata_q;     // Collected write data
   logic sda_oe_q, sda_out_q;
   logic [31:0] tmo_cnt_q;

   // Register set
   tss_pkg::tss_cfg_type cfg_q;
   logic [15:0] upper_q, lower_q, crit_q;
   logic [12:0] temp_q;
   logic [31:0] conv_cnt_q;
   logic event_sts_q, cond_prev_q;
   logic event_oe_q, event_out_q;

   // Edge and condition decode
   wire scl_rise = scl_s2_q & ~scl_s3_q;
   wire scl_fall = ~scl_s2_q & scl_s3_q;
   wire start_seen = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
   wire stop_seen = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
   wire byte_done = scl_fall && cnt_q == 4'h8;
   wire addr_match = shift_q[7:1] == {`TSS_ADDR_PREAMBLE, asel_s2_q};
   wire timeout_hit = tmo_cnt_q == 32'(TIMEOUT_CYCLES - 1);
   wire conv_tick = conv_cnt_q == 32'(CONV_CYCLES - 1);
   wire commit = stop_seen && wr_cnt_q == 2'h2;

   // Limit comparisons, limits aligned to the reading's quarter-degree bit
   wire signed [12:0] temp_s = temp_q;
   wire signed [12:0] upper_s = {upper_q[12:2], 2'h0};
   wire signed [12:0] lower_s = {lower_q[12:2], 2'h0};
   wire signed [12:0] crit_s = {crit_q[12:2], 2'h0};
   tss_pkg::tss_trip_type trip;
   assign trip.over_crit = temp_s > crit_s;
   assign trip.over_high = temp_s > upper_s;
   assign trip.under_low = temp_s < lower_s;
   wire cond = cfg_q.crit_only ? trip.over_crit : |trip;

   // Event pin level: disabled looks like not asserted in the chosen polarity
   wire shown = cfg_q.ctrl & event_sts_q;
   wire pin_level = cfg_q.pol ? shown : ~shown;

   // Read view of all eight registers
   wire [15:0] cfg_word = {5'h00, cfg_q.hyst, cfg_q.shdn, cfg_q.lock_crit, cfg_q.lock_alarm,
                           1'h0, shown, cfg_q.ctrl, cfg_q.crit_only, cfg_q.pol, cfg_q.mode};
   wire [15:0] temp_word = {trip, temp_q};
   logic [15:0] rd_word;
   assign rd_word = ptr_q == `TSS_PTR_CAPABILITY ? `TSS_CAPABILITY_VALUE :
                    ptr_q == `TSS_PTR_CONFIG ? cfg_word :
                    ptr_q == `TSS_PTR_UPPER ? upper_q :
                    ptr_q == `TSS_PTR_LOWER ? lower_q :
                    ptr_q == `TSS_PTR_CRITICAL ? crit_q :
                    ptr_q == `TSS_PTR_TEMPERATURE ? temp_word :
                    ptr_q == `TSS_PTR_MAKER ? MAKER_CODE : REVISION_CODE;
   wire [7:0] next_byte = byte_lo_q ? rd_word[7:0] : rd_word[15:8];

   // Configuration write permissions
   wire cfg_hit = commit && ptr_q == `TSS_PTR_CONFIG;
   wire locked = cfg_q.lock_crit | cfg_q.lock_alarm;
   wire clear_req = cfg_hit && wdata_q[`TSS_CFG_CLEAR];

   // Outputs straight from flip-flops
   assign sda_out = sda_out_q;
   assign sda_oe = sda_oe_q;
   assign event_out = event_out_q;
   assign event_oe = event_oe_q;

   // Two-stage synchronisers for scl, sda, address pins and sensor code; reset is used unsynchronised
   always_ff @(posedge clock) begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      asel_s1_q <= {address_select_bit2, address_select_bit1, address_select_bit0};
      asel_s2_q <= asel_s1_q;
      code_s1_q <= sensor_code;
      code_s2_q <= code_s1_q;
   end

   // Scl low timeout while a command is open
   always_ff @(posedge clock) begin
      if (reset || state_q == tss_pkg::ST_IDLE || scl_s2_q || timeout_hit) begin
         tmo_cnt_q <= 32'h0000_0000;
      end else begin
         tmo_cnt_q <= tmo_cnt_q + 32'h0000_0001;
      end
   end

   // Serial engine: sample on scl rise, change sda on scl fall
   always_ff @(posedge clock) begin
      sda_out_q <= 1'h0;
      if (reset) begin
         state_q <= tss_pkg::ST_IDLE;
         cnt_q <= 4'h0;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         rw_q <= 1'h0;
         byte_lo_q <= 1'h0;
         mack_q <= 1'h0;
         wr_cnt_q <= 2'h0;
         ptr_q <= `TSS_PTR_RESET;
         wdata_q <= `TSS_REG_RESET;
         sda_oe_q <= 1'h0;
      end else if (stop_seen || timeout_hit) begin
         // Stop or timeout closes the command and frees sda
         state_q <= tss_pkg::ST_IDLE;
         sda_oe_q <= 1'h0;
         wr_cnt_q <= 2'h0;
      end else if (start_seen) begin
         // Start or repeated start: expect an address
         state_q <= tss_pkg::ST_ADDR;
         cnt_q <= 4'h0;
         sda_oe_q <= 1'h0;
         wr_cnt_q <= 2'h0;
      end else begin
         unique case (state_q)
            tss_pkg::ST_IDLE: begin
               // Bus traffic ignored until start
               cnt_q <= 4'h0;
            end
            tss_pkg::ST_ADDR, tss_pkg::ST_PTR, tss_pkg::ST_WR: begin
               if (scl_rise) begin
                  shift_q <= {shift_q[6:0], sda_s2_q};
                  cnt_q <= cnt_q + 4'h1;
               end else if (byte_done) begin
                  cnt_q <= 4'h0;
                  if (state_q == tss_pkg::ST_ADDR) begin
                     // Only a matching address is answered
                     state_q <= addr_match ? tss_pkg::ST_ACK_ADDR : tss_pkg::ST_IDLE;
                     sda_oe_q <= addr_match;
                     rw_q <= shift_q[0];
                  end else if (state_q == tss_pkg::ST_PTR) begin
                     ptr_q <= shift_q[2:0];
                     state_q <= tss_pkg::ST_ACK_PTR;
                     sda_oe_q <= 1'h1;
                  end else begin
                     // First data byte is the high byte
                     if (wr_cnt_q == 2'h0) begin
                        wdata_q[15:8] <= shift_q;
                     end else if (wr_cnt_q == 2'h1) begin
                        wdata_q[7:0] <= shift_q;
                     end
                     if (wr_cnt_q != 2'h3) begin
                        wr_cnt_q <= wr_cnt_q + 2'h1;
                     end
                     state_q <= tss_pkg::ST_ACK_WR;
                     sda_oe_q <= 1'h1;
                  end
               end
            end
            tss_pkg::ST_ACK_ADDR: begin
               if (scl_fall) begin
                  if (rw_q) begin
                     // Read: start with the high byte of the pointed register
                     state_q <= tss_pkg::ST_RD;
                     tx_q <= rd_word[15:8];
                     sda_oe_q <= ~rd_word[15];
                     byte_lo_q <= 1'h1;
                  end else begin
                     state_q <= tss_pkg::ST_PTR;
                     sda_oe_q <= 1'h0;
                  end
               end
            end
            tss_pkg::ST_ACK_PTR, tss_pkg::ST_ACK_WR: begin
               if (scl_fall) begin
                  state_q <= tss_pkg::ST_WR;
                  sda_oe_q <= 1'h0;
               end
            end
            tss_pkg::ST_RD: begin
               if (scl_rise) begin
                  cnt_q <= cnt_q + 4'h1;
               end else if (byte_done) begin
                  // Release for the master's acknowledge slot
                  cnt_q <= 4'h0;
                  state_q <= tss_pkg::ST_ACK_RD;
                  sda_oe_q <= 1'h0;
               end else if (scl_fall) begin
                  sda_oe_q <= ~tx_q[6];
                  tx_q <= {tx_q[6:0], 1'h0};
               end
            end
            tss_pkg::ST_ACK_RD: begin
               if (scl_rise) begin
                  mack_q <= ~sda_s2_q;
               end else if (scl_fall) begin
                  if (mack_q) begin
                     // Acknowledged: keep sending, alternating bytes
                     state_q <= tss_pkg::ST_RD;
                     tx_q <= next_byte;
                     sda_oe_q <= ~next_byte[7];
                     byte_lo_q <= ~byte_lo_q;
                  end else begin
                     state_q <= tss_pkg::ST_IDLE;
                     sda_oe_q <= 1'h0;
                  end
               end
            end
         endcase
      end
   end

   // Conversion timer runs free of the serial engine
   always_ff @(posedge clock) begin
      if (reset || conv_tick) begin
         conv_cnt_q <= 32'h0000_0000;
      end else begin
         conv_cnt_q <= conv_cnt_q + 32'h0000_0001;
      end
   end

   // Latest reading, frozen while shut down
   always_ff @(posedge clock) begin
      if (reset) begin
         temp_q <= 13'h0000;
      end else if (conv_tick && !cfg_q.shdn) begin
         temp_q <= code_s2_q;
      end
   end

   // Writable registers, committed at stop
   always_ff @(posedge clock) begin
      if (reset) begin
         cfg_q <= '0;
         upper_q <= `TSS_REG_RESET;
         lower_q <= `TSS_REG_RESET;
         crit_q <= `TSS_REG_RESET;
      end else if (commit) begin
         if (ptr_q == `TSS_PTR_UPPER && !cfg_q.lock_alarm) begin
            upper_q <= wdata_q;
         end
         if (ptr_q == `TSS_PTR_LOWER && !cfg_q.lock_alarm) begin
            lower_q <= wdata_q;
         end
         if (ptr_q == `TSS_PTR_CRITICAL && !cfg_q.lock_crit) begin
            crit_q <= wdata_q;
         end
         if (cfg_hit) begin
            // Locks only set; mode bits frozen while a lock is set
            cfg_q.hyst <= wdata_q[`TSS_CFG_HYST_LSB+1:`TSS_CFG_HYST_LSB];
            cfg_q.shdn <= wdata_q[`TSS_CFG_SHDN];
            cfg_q.lock_crit <= cfg_q.lock_crit | wdata_q[`TSS_CFG_LOCK_CRIT];
            cfg_q.lock_alarm <= cfg_q.lock_alarm | wdata_q[`TSS_CFG_LOCK_ALARM];
            if (!locked) begin
               cfg_q.ctrl <= wdata_q[`TSS_CFG_CTRL];
               cfg_q.crit_only <= wdata_q[`TSS_CFG_CRIT_ONLY];
               cfg_q.pol <= wdata_q[`TSS_CFG_POL];
               cfg_q.mode <= wdata_q[`TSS_CFG_MODE];
            end
         end
      end
   end

   // Event status: comparator follows, interrupt latches until cleared
   always_ff @(posedge clock) begin
      if (reset) begin
         event_sts_q <= 1'h0;
         cond_prev_q <= 1'h0;
      end else if (!cfg_q.shdn) begin
         cond_prev_q <= cond;
         if (!cfg_q.mode) begin
            event_sts_q <= cond;
         end else if (cond && !cond_prev_q) begin
            event_sts_q <= 1'h1; // Set wins over a clear in the same cycle
         end else if (clear_req) begin
            event_sts_q <= 1'h0;
         end
      end
   end

   // Open-drain event pin
   always_ff @(posedge clock) begin
      event_out_q <= 1'h0;
      if (reset) begin
         event_oe_q <= 1'h0;
      end else begin
         event_oe_q <= ~pin_level;
      end
   end

   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   sequence s_addr_byte_ok;
      state_q == tss_pkg::ST_ADDR && byte_done && addr_match && !start_seen && !stop_seen
         && !timeout_hit;
   endsequence
   sequence s_ack_driven;
      state_q == tss_pkg::ST_ACK_ADDR && sda_oe_q;
   endsequence

   property p_stop_ends;
      stop_seen |=> state_q == tss_pkg::ST_IDLE && !sda_oe_q;
   endproperty
   a_stop_ends: assert property (p_stop_ends) else $error("Stop did not end command");

   property p_addr_ack;
      s_addr_byte_ok |=> s_ack_driven;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("Matching address not acked");

   property p_no_match_quiet;
      state_q == tss_pkg::ST_ADDR && byte_done && !addr_match |=> !sda_oe_q[*2];
   endproperty
   a_no_match_quiet: assert property (p_no_match_quiet) else $error("Foreign address acked");

   property p_commit_at_stop;
      !$stable(upper_q) || !$stable(crit_q) |-> $past(stop_seen);
   endproperty
   a_commit_at_stop: assert property (p_commit_at_stop) else $error("Limit changed off stop");

   property p_shutdown_freeze;
      cfg_q.shdn && $past(cfg_q.shdn) |-> $stable(temp_q);
   endproperty
   a_shutdown_freeze: assert property (p_shutdown_freeze) else $error("Reading moved in shutdown");

   property p_trip_bits;
      temp_word[14] == ($signed(temp_q) > $signed({upper_q[12:2], 2'h0}))
         && temp_word[13] == ($signed(temp_q) < $signed({lower_q[12:2], 2'h0}));
   endproperty
   a_trip_bits: assert property (p_trip_bits) else $error("Trip bits disagree");

   property p_timeout;
      timeout_hit |=> state_q == tss_pkg::ST_IDLE && !sda_oe_q;
   endproperty
   a_timeout: assert property (p_timeout) else $error("Timeout did not reset");

   property p_conversion;
      conv_tick && !cfg_q.shdn |=> temp_q == $past(code_s2_q);
   endproperty
   a_conversion: assert property (p_conversion) else $error("Conversion not stored");

   property p_drive_on_fall;
      $rose(sda_oe_q) |-> $past(scl_fall);
   endproperty
   a_drive_on_fall: assert property (p_drive_on_fall) else $error("Sda driven off scl fall");

   property p_ptr_hold;
      !$stable(ptr_q) |-> $past(state_q == tss_pkg::ST_PTR && byte_done);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("Pointer moved unexpectedly");

   property p_comparator_event;
      !cfg_q.shdn && !cfg_q.mode |=> event_sts_q == $past(cond);
   endproperty
   a_comparator_event: assert property (p_comparator_event) else $error("Event not evaluated");
endmodule : tss_slave
